// File: common/bpgd_pkg.sv
// Purpose: Constants and carrier types for the buck phase grouping decoder
// Assumes: One 100 MHz clock, register port with one-cycle read latency
// Notes: What this block does
// What this block does
// - Group-one code 10 gangs channels one to four; code 11 gangs one to three.
// - Group-one code 00 keeps one, two single; 01 pairs them; channel one governs.
// - With one to three ganged, channel four stays single under its own settings.
// - Channels three and four paired take every setting but phase shift from channel four.
// - Group-four code 00 is single, 01 is dual; 10 and 11 are reserved.
// - Triple or quad group-one modes override the group-four field.
// - Channels five and six paired take every setting but phase shift from channel five.
// - Group-five code 00 is single, 01 is dual; 10 and 11 are reserved.
// - Every ganged phase keeps its own phase-shift selection.
// - Triple and quad rails take their current limit from channel one.
// - Ramp bit clear gives 6.25 mV/us, set gives 12.5 mV/us.
package bpgd_pkg;
   localparam int NUM_CHAN = 6;
   // ****************************************************************
   // Grouping codes
   // ****************************************************************
   localparam logic [1:0] CFG_SINGLE = 2'h0;
   localparam logic [1:0] CFG_DUAL = 2'h1;
   localparam logic [1:0] CFG_QUAD = 2'h2;
   localparam logic [1:0] CFG_TRIPLE = 2'h3;
   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [7:0] CHAN_BASE = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h18;
   localparam logic [7:0] LEVEL_BASE = 8'h20;
   localparam int VOUT_LSB = 0;
   localparam int ILIM_LSB = 8;
   localparam int PHASE_LSB = 10;
   localparam int RAMP_BIT = 13;
   localparam int ENABLE_BIT = 14;
   localparam int LATCHED_BIT = 8;
   localparam int AT_TARGET_BIT = 8;
   localparam logic [7:0] VOUT_RESET = 8'h00;
   localparam logic [1:0] ILIM_RESET = 2'h0;
   localparam logic [2:0] PHASE_RESET = 3'h7;
   // ****************************************************************
   // Timing: one voltage code is 6.25 mV, so one step per half or
   // whole microsecond gives the two ramp slopes
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int HALF_STEP_NS = 500;
   localparam int HALF_STEP_CYCLES = HALF_STEP_NS / CLK_PERIOD_NS;
   localparam int SLOPE_SLOW_UV_PER_US = 6250;
   localparam int SLOPE_FAST_UV_PER_US = 12500;
   localparam logic [1:0] LATCH_DELAY = 2'h3;
   // ****************************************************************
   // Carrier types
   // ****************************************************************
   typedef struct packed {
      logic enable;
      logic ramp;
      logic [2:0] phase;
      logic [1:0] ilim;
      logic [7:0] vout;
   } bpgd_chan_set_type;
   typedef struct packed {
      logic [2:0] gov;
      logic [2:0] phases;
   } bpgd_map_type;
   typedef struct packed {
      logic [2:0] gov;
      logic [2:0] phases;
      logic [2:0] phase;
      logic [1:0] ilim;
      logic ramp;
      logic [7:0] target;
      logic [7:0] level;
      logic enable;
   } bpgd_chan_out_type;
endpackage : bpgd_pkg

// File: hw/bpgd_group_decode.sv
// Purpose: Map grouping codes to governing channel and phase count
// Assumes: Codes already latched and stable
// Notes: Channel indices are one-based
`timescale 1ns/10ps
module bpgd_group_decode (
   input wire logic [1:0] group_one_config,
   input wire logic [1:0] group_four_config,
   input wire logic [1:0] group_five_config,
   output bpgd_pkg::bpgd_map_type [5:0] map
);
   logic g1_multi;
   logic g4_dual;
   logic g5_dual;
   always_comb begin
      g1_multi = (group_one_config == bpgd_pkg::CFG_QUAD) ||
                 (group_one_config == bpgd_pkg::CFG_TRIPLE);
      // Reserved codes fall through to single phase
      g4_dual = !g1_multi &&
                (group_four_config == bpgd_pkg::CFG_DUAL);
      g5_dual = (group_five_config == bpgd_pkg::CFG_DUAL);
      map[0] = '{gov: 3'h1, phases: 3'h1};
      map[1] = '{gov: 3'h2, phases: 3'h1};
      map[2] = '{gov: 3'h3, phases: 3'h1};
      map[3] = '{gov: 3'h4, phases: 3'h1};
      map[4] = '{gov: 3'h5, phases: 3'h1};
      map[5] = '{gov: 3'h6, phases: 3'h1};
      case (group_one_config)
         bpgd_pkg::CFG_DUAL: begin
            map[0].phases = 3'h2;
            map[1] = '{gov: 3'h1, phases: 3'h2};
         end
         bpgd_pkg::CFG_QUAD: begin
            map[0].phases = 3'h4;
            map[1] = '{gov: 3'h1, phases: 3'h4};
            map[2] = '{gov: 3'h1, phases: 3'h4};
            map[3] = '{gov: 3'h1, phases: 3'h4};
         end
         bpgd_pkg::CFG_TRIPLE: begin
            map[0].phases = 3'h3;
            map[1] = '{gov: 3'h1, phases: 3'h3};
            map[2] = '{gov: 3'h1, phases: 3'h3};
         end
         default: begin
            map[0].phases = 3'h1;
         end
      endcase
      if (g4_dual) begin
         map[2] = '{gov: 3'h4, phases: 3'h2};
         map[3] = '{gov: 3'h4, phases: 3'h2};
      end
      if (g5_dual) begin
         map[4] = '{gov: 3'h5, phases: 3'h2};
         map[5] = '{gov: 3'h5, phases: 3'h2};
      end
   end
endmodule : bpgd_group_decode

// File: hw/bpgd_sync.sv
// Purpose: Two-stage synchroniser for pin levels
// Assumes: Inputs are static or slow levels
// Notes: First stage feeds only the second stage
`timescale 1ns/10ps
module bpgd_sync #(
   parameter int WIDTH = 6
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } bpgd_sync_state_type;
   bpgd_sync_state_type st;
   bpgd_sync_state_type next_st;
   if (WIDTH < 1) begin : g_check
      $error("bpgd_sync WIDTH must be at least one");
   end
   always_comb begin
      next_st.s1 = din;
      next_st.s2 = st.s1;
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign dout = st.s2;
endmodule : bpgd_sync

// File: hw/bpgd_top.sv
// Purpose: Buck phase grouping decoder with per-channel settings and ramp
// Assumes: OTP grouping pins are levels from outside the clock domain
// Notes: Grouping is captured once after reset and held
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
module bpgd_top (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [1:0] otp_group_one_config,
   input wire logic [1:0] otp_group_four_config,
   input wire logic [1:0] otp_group_five_config,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   output logic config_latched,
   output bpgd_pkg::bpgd_chan_out_type [5:0] chan_out
);
   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [1:0] group_one_config;
      logic [1:0] group_four_config;
      logic [1:0] group_five_config;
      logic latched;
      logic [1:0] settle;
      logic [5:0] tick_div;
      logic slow_phase;
      bpgd_pkg::bpgd_chan_set_type [5:0] set;
      logic [5:0][7:0] level;
      logic [31:0] rdata;
   } bpgd_top_state_type;
   bpgd_top_state_type st;
   bpgd_top_state_type next_st;
   logic [5:0] otp_sync;
   bpgd_pkg::bpgd_map_type [5:0] map;
   logic half_tick;
   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Channel index of a per-channel word, or 7 when outside the bank
   function automatic logic [2:0] chan_index(
      input logic [7:0] addr,
      input logic [7:0] base
   );
      logic [7:0] off;
      off = addr - base;
      if (addr[1:0] != 2'h0) begin
         chan_index = 3'h7;
      end else if (addr < base) begin
         chan_index = 3'h7;
      end else if (off[7:2] >= 6'(bpgd_pkg::NUM_CHAN)) begin
         chan_index = 3'h7;
      end else begin
         chan_index = off[4:2];
      end
   endfunction : chan_index
   function automatic logic [31:0] pack_set(
      input bpgd_pkg::bpgd_chan_set_type s
   );
      logic [31:0] w;
      w = '0;
      w[bpgd_pkg::VOUT_LSB +: 8] = s.vout;
      w[bpgd_pkg::ILIM_LSB +: 2] = s.ilim;
      w[bpgd_pkg::PHASE_LSB +: 3] = s.phase;
      w[bpgd_pkg::RAMP_BIT] = s.ramp;
      w[bpgd_pkg::ENABLE_BIT] = s.enable;
      pack_set = w;
   endfunction : pack_set
   // ****************************************************************
   // Pin synchronisation and grouping decode
   // ****************************************************************
   bpgd_sync #(
      .WIDTH(6)
   ) u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .din({otp_group_five_config, otp_group_four_config,
            otp_group_one_config}),
      .dout(otp_sync)
   );
   bpgd_group_decode u_decode (
      .group_one_config(st.group_one_config),
      .group_four_config(st.group_four_config),
      .group_five_config(st.group_five_config),
      .map(map)
   );
   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      logic [2:0] widx;
      logic [2:0] ridx;
      logic [2:0] lidx;
      logic step;
      widx = chan_index(reg_addr, bpgd_pkg::CHAN_BASE);
      ridx = chan_index(reg_addr, bpgd_pkg::CHAN_BASE);
      lidx = chan_index(reg_addr, bpgd_pkg::LEVEL_BASE);
      step = 1'b0;
      next_st = st;
      // Capture grouping once the synchroniser has settled
      if (!st.latched) begin
         if (st.settle == bpgd_pkg::LATCH_DELAY) begin
            next_st.group_one_config = otp_sync[1:0];
            next_st.group_four_config = otp_sync[3:2];
            next_st.group_five_config = otp_sync[5:4];
            next_st.latched = 1'b1;
         end else begin
            next_st.settle = st.settle + 2'h1;
         end
      end
      // Half-microsecond tick divider
      if (st.tick_div == 6'(bpgd_pkg::HALF_STEP_CYCLES - 1)) begin
         next_st.tick_div = '0;
         next_st.slow_phase = ~st.slow_phase;
      end else begin
         next_st.tick_div = st.tick_div + 6'h1;
      end
      // Register writes
      if (reg_write && widx != 3'h7) begin
         next_st.set[widx].vout = reg_wdata[bpgd_pkg::VOUT_LSB +: 8];
         next_st.set[widx].ilim = reg_wdata[bpgd_pkg::ILIM_LSB +: 2];
         next_st.set[widx].phase = reg_wdata[bpgd_pkg::PHASE_LSB +: 3];
         next_st.set[widx].ramp = reg_wdata[bpgd_pkg::RAMP_BIT];
         next_st.set[widx].enable = reg_wdata[bpgd_pkg::ENABLE_BIT];
      end
      // Register reads, answered in the next cycle
      next_st.rdata = '0;
      if (reg_read) begin
         if (ridx != 3'h7) begin
            next_st.rdata = pack_set(st.set[ridx]);
         end else if (reg_addr == bpgd_pkg::STATUS_ADDR) begin
            next_st.rdata[5:0] = {st.group_five_config,
                                  st.group_four_config,
                                  st.group_one_config};
            next_st.rdata[bpgd_pkg::LATCHED_BIT] = st.latched;
         end else if (lidx != 3'h7) begin
            next_st.rdata[7:0] = st.level[lidx];
            next_st.rdata[bpgd_pkg::AT_TARGET_BIT] =
               (st.level[lidx] == st.set[lidx].vout);
         end else begin
            next_st.rdata = '0;
         end
      end
      // Per-channel turn-on ramp: one code of 6.25 mV per step
      for (int c = 0; c < bpgd_pkg::NUM_CHAN; c++) begin
         step = half_tick && (st.set[c].ramp || st.slow_phase);
         if (!st.set[c].enable) begin
            next_st.level[c] = '0;
         end else if (step && st.level[c] < st.set[c].vout) begin
            next_st.level[c] = st.level[c] + 8'h1;
         end else if (step && st.level[c] > st.set[c].vout) begin
            next_st.level[c] = st.level[c] - 8'h1;
         end
      end
   end
   assign half_tick =
      (st.tick_div == 6'(bpgd_pkg::HALF_STEP_CYCLES - 1));
   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
         for (int c = 0; c < bpgd_pkg::NUM_CHAN; c++) begin
            st.set[c].vout <= bpgd_pkg::VOUT_RESET;
            st.set[c].ilim <= bpgd_pkg::ILIM_RESET;
            st.set[c].phase <= bpgd_pkg::PHASE_RESET;
         end
      end else begin
         st <= next_st;
      end
   end
   // ****************************************************************
   // Effective per-phase outputs
   // ****************************************************************
   always_comb begin
      logic [2:0] gi;
      gi = 3'h0;
      for (int c = 0; c < bpgd_pkg::NUM_CHAN; c++) begin
         gi = map[c].gov - 3'h1;
         chan_out[c].gov = map[c].gov;
         chan_out[c].phases = map[c].phases;
         chan_out[c].phase = st.set[c].phase;
         chan_out[c].ilim = st.set[gi].ilim;
         chan_out[c].ramp = st.set[gi].ramp;
         chan_out[c].target = st.set[gi].vout;
         chan_out[c].level = st.level[gi];
         chan_out[c].enable = st.set[gi].enable && st.latched;
      end
   end
   assign reg_rdata = st.rdata;
   assign config_latched = st.latched;
endmodule : bpgd_top

// File: sim/bpgd_top_asserts.sv
// Purpose: Port checks for the grouping decoder
// Assumes: Sees only top ports
// Notes: Shadows follow writes and the captured grouping codes
`timescale 1ns/10ps
module bpgd_top_asserts (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [1:0] otp_group_one_config,
   input wire logic [1:0] otp_group_four_config,
   input wire logic [1:0] otp_group_five_config,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic config_latched,
   input wire bpgd_pkg::bpgd_chan_out_type [5:0] chan_out
);
   logic [2:0] cnt;
   logic [5:0] lg;
   logic [14:0] sh [6];
   logic [35:0] mb;
   // ****
   // Helper state
   // ****
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt <= 3'h0;
         lg <= 6'h00;
         for (int i = 0; i < 6; i++) sh[i] <= 15'h1c00;
      end else begin
         if (cnt != 3'h7) cnt <= cnt + 3'h1;
         if (!config_latched) lg <= {otp_group_five_config,
            otp_group_four_config, otp_group_one_config};
         if (reg_write && reg_addr[1:0] == 2'h0 && reg_addr < 8'h18)
            sh[reg_addr[4:2]] <= reg_wdata[14:0];
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ****
   // Properties
   // ****
   a_latch_time: assert property (config_latched == (cnt >= 3'h4))
      else $error("latch moment wrong");
   a_latch_hold: assert property (config_latched |=> config_latched)
      else $error("latch dropped");
   a_map_still: assert property (config_latched |=> $stable(mb))
      else $error("map moved");
   a_read_idle: assert property (!reg_read |=> reg_rdata == 32'h0)
      else $error("read data outside slot");
   a_quad_gang: assert property (config_latched && lg[1:0] == 2'h2
      |-> mb[23:0] == {4{6'h0c}})
      else $error("quad map wrong");
   a_triple_gang: assert property (config_latched && lg[1:0] == 2'h3
      |-> mb[23:0] == {6'h21, {3{6'h0b}}})
      else $error("triple map wrong");
   a_pair_mid: assert property (config_latched && !lg[1] && lg[3:2] == 2'h1
      |-> mb[23:12] == {2{6'h22}})
      else $error("pair three four wrong");
   a_resv_mid: assert property (config_latched && !lg[1] && lg[3]
      |-> mb[23:12] == {6'h21, 6'h19})
      else $error("reserved mid code not single");
   a_pair_top: assert property (config_latched && lg[5:4] == 2'h1
      |-> mb[35:24] == {2{6'h2a}})
      else $error("pair five six wrong");
   a_resv_top: assert property (config_latched && lg[5]
      |-> mb[35:24] == {6'h31, 6'h29})
      else $error("reserved top code not single");
   for (genvar c = 0; c < 6; c++) begin : g_ch
      assign mb[6*c +: 6] = {chan_out[c].gov, chan_out[c].phases};
      a_own_phase: assert property (chan_out[c].phase == sh[c][12:10])
         else $error("phase not own");
      a_gov_set: assert property ({chan_out[c].ilim, chan_out[c].ramp,
         chan_out[c].target} == {sh[chan_out[c].gov - 3'h1][9:8],
         sh[chan_out[c].gov - 3'h1][13],
         sh[chan_out[c].gov - 3'h1][7:0]})
         else $error("settings not from governor");
      a_gov_en: assert property (chan_out[c].enable ==
         (sh[chan_out[c].gov - 3'h1][14] && config_latched))
         else $error("enable wrong");
   end
endmodule : bpgd_top_asserts

// File: sim/bpgd_top_tb.sv
// Purpose: Self-checking bench for the grouping decoder
// Assumes: Grouping pins stable from reset release
// Notes: Every grouping code combination is latched once in the sweep, all-zero again for the ramp checks
`timescale 1ns/10ps
module bpgd_top_tb;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [5:0] pins = 6'h00;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic latched;
   bpgd_pkg::bpgd_chan_out_type [5:0] co;
   logic [31:0] w [6];
   logic [15:0] seed = 16'h002e;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;
   always #5 sys_clk = ~sys_clk;
   bpgd_top u_dut (.sys_clk(sys_clk), .rst(rst),
      .otp_group_one_config(pins[1:0]), .otp_group_four_config(pins[3:2]),
      .otp_group_five_config(pins[5:4]), .reg_addr(addr),
      .reg_wdata(wdata), .reg_write(wr), .reg_read(rd),
      .reg_rdata(rdata), .config_latched(latched), .chan_out(co));
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 12000) begin
         n_fail++;
         wrap_up();
      end
   end
   task automatic chk(input string nm, input logic [31:0] s,
      input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         n_fail++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rreg
   task automatic restart(input logic [5:0] k);
      int n;
      @(posedge sys_clk);
      rst <= 1'b1;
      pins <= k;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      n = 0;
      while (latched !== 1'b1 && n < 20) begin
         @(posedge sys_clk);
         #1 n++;
      end
   endtask : restart
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // Expected governor and phase count of channel c
   function automatic logic [5:0] mdl(input int c, input logic [5:0] k);
      if (c < 2 && k[1:0] != 2'h0)
         return {3'h1, k[1] ? (k[0] ? 3'h3 : 3'h4) : 3'h2};
      if (c == 2 && k[1]) return {3'h1, k[0] ? 3'h3 : 3'h4};
      if (c == 3 && k[1:0] == 2'h2) return 6'h0c;
      if (c > 1 && c < 4 && !k[1] && k[3:2] == 2'h1) return 6'h22;
      if (c > 3 && k[5:4] == 2'h1) return 6'h2a;
      return {3'(c + 1), 3'h1};
   endfunction : mdl
   initial begin
      logic [31:0] d;
      logic [5:0] m;
      int g;
      int n;
      repeat (20) @(posedge sys_clk);
      for (int k = 0; k < 64; k++) begin
         restart(6'(k));
         for (int c = 0; c < 6; c++) begin
            seed = lfsr(seed);
            w[c] = {17'h0, seed[14:0]};
            wreg(8'(4 * c), w[c]);
         end
         @(posedge sys_clk);
         #1;
         for (int c = 0; c < 6; c++) begin
            m = mdl(c, 6'(k));
            g = int'(m[5:3]) - 1;
            chk("gov", co[c].gov, m[5:3]);
            chk("phases", co[c].phases, m[2:0]);
            chk("phase", co[c].phase, w[c][12:10]);
            chk("ilim", co[c].ilim, w[g][9:8]);
            chk("target", co[c].target, w[g][7:0]);
            chk("ramp", co[c].ramp, w[g][13]);
            chk("enable", co[c].enable, w[g][14]);
         end
         wreg(8'h18, 32'hffffffff);
         rreg(8'h18, d);
         chk("status", d, {23'h0, 1'b1, 2'h0, 6'(k)});
         rreg(8'(4 * (k % 6)), d);
         chk("readback", d, w[k % 6] & 32'h7fff);
         rreg(k[0] ? 8'h38 : 8'h01, d);
         chk("unmapped", d, 32'h0);
      end
      restart(6'h00);
      for (int f = 0; f < 2; f++) begin
         wreg(8'h00, {17'h0, 1'b1, f[0], 3'h7, 2'h0, 8'h04});
         n = 0;
         while (co[0].level !== 8'h04 && n < 1000) begin
            @(posedge sys_clk);
            #1 n++;
         end
         chk("ramp time", 32'(n > 150 * (2 - f) && n <= 200 * (2 - f) + 2),
            32'h1);
         rreg(8'h20, d);
         chk("level", d, 32'h104);
         wreg(8'h00, 32'h0);
         @(posedge sys_clk);
         #1;
         chk("off", co[0].level, 32'h0);
      end
      wrap_up();
   end
endmodule : bpgd_top_tb
bind bpgd_top bpgd_top_asserts u_chk (.sys_clk(sys_clk), .rst(rst),
   .otp_group_one_config(otp_group_one_config),
   .otp_group_four_config(otp_group_four_config),
   .otp_group_five_config(otp_group_five_config),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
   .reg_read(reg_read), .reg_rdata(reg_rdata),
   .config_latched(config_latched), .chan_out(chan_out));
